//--- logic/pmc_pkg.sv
/*
 PHY management controller package: register byte offsets, field bit positions,
 command codes, management frame layout and timing constants.
 Assumes byte-wide register accesses and a 20 MHz system clock.
*/
package pmc_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [11:0] OFS_CTRL_LO = 12'h510;
    localparam logic [11:0] OFS_CTRL_HI = 12'h511;
    localparam logic [11:0] OFS_PHY_ADDR = 12'h512;
    localparam logic [11:0] OFS_REG_SEL = 12'h513;
    localparam logic [11:0] OFS_DATA_LO = 12'h514;
    localparam logic [11:0] OFS_DATA_HI = 12'h515;
    localparam logic [11:0] OFS_M_CLAIM = 12'h516;
    localparam logic [11:0] OFS_L_CLAIM = 12'h517;
    localparam logic [11:0] OFS_STAT_0 = 12'h518;
    localparam logic [11:0] OFS_STAT_1 = 12'h519;
    localparam logic [11:0] OFS_STAT_2 = 12'h51A;
    localparam logic [11:0] OFS_STAT_3 = 12'h51B;
    // ==========================================================
    // bit positions inside a byte
    localparam int BIT_WE = 0;
    localparam int BIT_SHOW_IND = 7;
    localparam int BIT_CLAIM = 0;
    localparam int BIT_FORCE = 1;
    localparam int BIT_BUSY = 7;
    localparam int BIT_CMD_ERR = 6;
    localparam int BIT_RD_ERR = 5;
    // ==========================================================
    // command codes and frame fields
    localparam logic [1:0] CMD_IDLE = 2'h0;
    localparam logic [1:0] CMD_READ = 2'h1;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] FRM_START = 2'h1;
    localparam logic [1:0] FRM_OP_RD = 2'h2;
    localparam logic [1:0] FRM_OP_WR = 2'h1;
    localparam logic [1:0] FRM_TA_WR = 2'h2;
    localparam logic [31:0] FRM_PREAMBLE = 32'hFFFFFFFF;
    localparam logic [6:0] FRM_LAST_BIT = 7'h3F;
    localparam logic [6:0] FRM_RELEASE_BIT = 7'h2E;
    localparam logic [6:0] FRM_TA_BIT = 7'h2F;
    localparam logic [6:0] FRM_DATA_BIT = 7'h30;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // ==========================================================
    // timing: management clock derived from system clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int MDC_PERIOD_NS = 1000;
    localparam int MDC_HALF_CYC = (MDC_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRAME_CYCLES = 64 * 2 * MDC_HALF_CYC;
    localparam logic [4:0] DIV_LAST = 5'(MDC_HALF_CYC - 1);
    typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_SHIFT = 2'h2} pmc_state_e;
endpackage

//--- logic/pmc_controller.sv
/*
 PHY management controller: control/status and address/data registers reached
 by two hosts (network master side and local host port), and the management
 serial frame engine towards the external PHYs.
 Assumes host strobes, sof and strap inputs are synchronous to ref_clk;
 only mdio_in is asynchronous.
*/
// Operation
// - write-enable bit 0 reads one whenever local host port owns the unit
// - bit 1 reports whether local host port may take over control
// - bit 2 reports whether management-link detection is active
// - bits 7:3 return configured Phy_target_address of port 0, or the selected port's own address when the select bit is set and phy_addr < NUM_PORTS
// - command bits 9:8: 00 idle clears errors, 01 read, 10 write
// - command field reads back the command being executed
// - read error bit 13 set when PHY does not respond
// - any accepted host write to control/status clears read error
// - command error bit 14 on invalid code or write without enable
// - command error cleared by valid command or idle code
// - bit 15 busy while the frame engine runs
// - writes to management registers ignored while busy
// - only the owning host may write the gated fields
// - write enable clears at next frame start or local access end
// - command field returns to idle when busy ends
// - idle code clears both error flags together
// - five-bit Phy_target_address selects target; select bit picks shown address
// - five-bit register address selects register inside the PHY
// - ownership bit: 0 network master side, 1 local host port
`timescale 1ns/1ps
module pmc_controller #(
    parameter int NUM_PORTS = 4
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [11:0] m_addr,
    input wire logic m_wr,
    input wire logic m_rd,
    input wire logic [7:0] m_wdata,
    output logic [7:0] m_rdata,
    input wire logic [11:0] l_addr,
    input wire logic l_wr,
    input wire logic l_rd,
    input wire logic [7:0] l_wdata,
    output logic [7:0] l_rdata,
    input wire logic sof,
    input wire logic l_access_end,
    input wire logic lh_ctrl_possible,
    input wire logic link_detect_active,
    input wire logic [4:0] port0_phy_addr,
    input wire logic [5*NUM_PORTS-1:0] port_phy_addrs,
    input wire logic [8*NUM_PORTS-1:0] port_link_status,
    output logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n
);
    // ==========================================================
    // state
    typedef struct packed {
        pmc_pkg::pmc_state_e state;
        logic we;
        logic [1:0] cmd;
        logic rd_err;
        logic cmd_err;
        logic [4:0] phy_addr;
        logic show_ind;
        logic [7:0] reg_sel;
        logic [15:0] data;
        logic m_claim;
        logic l_claim;
        logic [4:0] div_cnt;
        logic mdc;
        logic [6:0] bit_cnt;
        logic [63:0] shreg;
        logic [15:0] rx;
        logic ta_fail;
        logic mdio_o;
        logic mdio_oe_n;
        logic mdi_s1;
        logic mdi_s2;
        logic [7:0] m_rdata;
        logic [7:0] l_rdata;
        logic [11:0] busy_cnt;
    } pmc_regs_s;

    pmc_regs_s r_r;
    pmc_regs_s r_nxt;
    logic busy;
    logic we_eff;
    logic m_wr_ok;
    logic l_wr_ok;
    logic wr_ok;
    logic [11:0] wa;
    logic [7:0] wd;
    logic [4:0] disp_addr;
    logic [7:0] ctrl_lo;
    logic [7:0] ctrl_hi;
    logic is_read;

    // ==========================================================
    // write qualification and readback words
    // busy follows the engine
    assign busy = (r_r.state == pmc_pkg::ST_SHIFT);
    // local owner always sees writes enabled
    assign we_eff = r_r.we | r_r.l_claim;
    // busy blocks writes; only the owner gets through
    assign m_wr_ok = m_wr && !r_r.l_claim && !busy;
    assign l_wr_ok = l_wr && r_r.l_claim && !busy;
    assign wr_ok = m_wr_ok | l_wr_ok;
    assign wa = m_wr_ok ? m_addr : l_addr;
    assign wd = m_wr_ok ? m_wdata : l_wdata;
    assign is_read = (r_r.cmd == pmc_pkg::CMD_READ);
    // shown address is port 0 offset or a port's own address
    assign disp_addr = (r_r.show_ind && (r_r.phy_addr < 5'(NUM_PORTS)))
        ? port_phy_addrs[5 * r_r.phy_addr[1:0] +: 5] : port0_phy_addr;
    // takeover possible; link detection; shown address
    assign ctrl_lo = {disp_addr, link_detect_active, lh_ctrl_possible, we_eff};
    // command field shows the running command
    assign ctrl_hi = {busy, r_r.cmd_err, r_r.rd_err, 3'h0, r_r.cmd};

    // byte readback mux; unmapped offsets read zero
    function automatic logic [7:0] rd_byte(input logic [11:0] a);
        logic [7:0] v;
        v = pmc_pkg::RST_BYTE;
        unique case (a)
            pmc_pkg::OFS_CTRL_LO: v = ctrl_lo;
            pmc_pkg::OFS_CTRL_HI: v = ctrl_hi;
            pmc_pkg::OFS_PHY_ADDR: v = {r_r.show_ind, 2'h0, r_r.phy_addr};
            pmc_pkg::OFS_REG_SEL: v = r_r.reg_sel;
            pmc_pkg::OFS_DATA_LO: v = r_r.data[7:0];
            pmc_pkg::OFS_DATA_HI: v = r_r.data[15:8];
            pmc_pkg::OFS_M_CLAIM: v = {7'h00, r_r.m_claim};
            pmc_pkg::OFS_L_CLAIM: v = {7'h00, r_r.l_claim};
            pmc_pkg::OFS_STAT_0: v = port_link_status[7:0];
            pmc_pkg::OFS_STAT_1: v = port_link_status[15:8];
            pmc_pkg::OFS_STAT_2: v = port_link_status[23:16];
            pmc_pkg::OFS_STAT_3: v = port_link_status[31:24];
            default: v = pmc_pkg::RST_BYTE;
        endcase
        return v;
    endfunction

    // ==========================================================
    // next-state logic
    always_comb
    begin
        r_nxt = r_r;
        // two-stage synchroniser on the serial data input
        r_nxt.mdi_s1 = mdio_in;
        r_nxt.mdi_s2 = r_r.mdi_s1;
        // busy-cycle count, read only by the frame length check
        r_nxt.busy_cnt = busy ? r_r.busy_cnt + 12'h001 : 12'h000;
        if (m_rd)
        begin
            r_nxt.m_rdata = rd_byte(m_addr);
        end
        if (l_rd)
        begin
            r_nxt.l_rdata = rd_byte(l_addr);
        end
        // self-clear first so a same-cycle master write wins
        if (sof || l_access_end)
        begin
            r_nxt.we = 1'b0;
        end
        if (m_wr_ok && wa == pmc_pkg::OFS_CTRL_LO)
        begin
            r_nxt.we = wd[pmc_pkg::BIT_WE];
        end
        // ownership; master may force it back to itself
        if (m_wr && !r_r.l_claim && m_addr == pmc_pkg::OFS_M_CLAIM)
        begin
            r_nxt.m_claim = m_wdata[pmc_pkg::BIT_CLAIM];
        end
        if (l_wr && l_addr == pmc_pkg::OFS_L_CLAIM && !r_r.m_claim && lh_ctrl_possible)
        begin
            r_nxt.l_claim = l_wdata[pmc_pkg::BIT_CLAIM];
        end
        if (m_wr && m_addr == pmc_pkg::OFS_L_CLAIM && m_wdata[pmc_pkg::BIT_FORCE])
        begin
            r_nxt.l_claim = 1'b0;
        end
        if (wr_ok && wa == pmc_pkg::OFS_PHY_ADDR)
        begin
            r_nxt.phy_addr = wd[4:0];
            r_nxt.show_ind = wd[pmc_pkg::BIT_SHOW_IND];
        end
        if (wr_ok && wa == pmc_pkg::OFS_REG_SEL)
        begin
            r_nxt.reg_sel = wd;
        end
        if (wr_ok && wa == pmc_pkg::OFS_DATA_LO)
        begin
            r_nxt.data[7:0] = wd;
        end
        if (wr_ok && wa == pmc_pkg::OFS_DATA_HI)
        begin
            r_nxt.data[15:8] = wd;
        end
        // any accepted write to control/status clears read error
        if (wr_ok && (wa == pmc_pkg::OFS_CTRL_LO || wa == pmc_pkg::OFS_CTRL_HI))
        begin
            r_nxt.rd_err = 1'b0;
        end
        unique case (r_r.state)
            pmc_pkg::ST_IDLE:
            begin
                // command decode on the upper control byte
                if (wr_ok && wa == pmc_pkg::OFS_CTRL_HI)
                begin
                    unique case (wd[1:0])
                        pmc_pkg::CMD_IDLE:
                        begin
                            r_nxt.cmd_err = 1'b0;
                            r_nxt.rd_err = 1'b0;
                        end
                        pmc_pkg::CMD_READ,
                        pmc_pkg::CMD_WRITE:
                        begin
                            // write without enable is a command error
                            if (wd[1:0] == pmc_pkg::CMD_WRITE && !we_eff)
                            begin
                                r_nxt.cmd_err = 1'b1;
                            end
                            else
                            begin
                                // a valid command clears command error
                                r_nxt.cmd_err = 1'b0;
                                r_nxt.state = pmc_pkg::ST_SHIFT;
                                r_nxt.cmd = wd[1:0];
                                r_nxt.shreg = {pmc_pkg::FRM_PREAMBLE, pmc_pkg::FRM_START,
                                    (wd[1:0] == pmc_pkg::CMD_READ) ? pmc_pkg::FRM_OP_RD
                                    : pmc_pkg::FRM_OP_WR,
                                    r_r.phy_addr, r_r.reg_sel[4:0], pmc_pkg::FRM_TA_WR,
                                    r_r.data};
                                r_nxt.mdio_o = 1'b1;
                                r_nxt.mdio_oe_n = 1'b0;
                                r_nxt.bit_cnt = 7'h00;
                                r_nxt.div_cnt = 5'h00;
                                r_nxt.mdc = 1'b0;
                                r_nxt.ta_fail = 1'b0;
                            end
                        end
                        // reserved code is refused as a command error
                        default:
                        begin
                            r_nxt.cmd_err = 1'b1;
                        end
                    endcase
                end
            end
            pmc_pkg::ST_SHIFT:
            begin
                // half-period divider sets the management clock rate
                r_nxt.div_cnt = r_r.div_cnt + 5'h01;
                if (r_r.div_cnt == pmc_pkg::DIV_LAST)
                begin
                    r_nxt.div_cnt = 5'h00;
                    r_nxt.mdc = !r_r.mdc;
                    if (!r_r.mdc)
                    begin
                        // rising edge: sample turnaround and read data
                        // a PHY that answers pulls the turnaround low
                        if (is_read && r_r.bit_cnt == pmc_pkg::FRM_TA_BIT && r_r.mdi_s2)
                        begin
                            r_nxt.ta_fail = 1'b1;
                        end
                        if (is_read && r_r.bit_cnt >= pmc_pkg::FRM_DATA_BIT)
                        begin
                            r_nxt.rx = {r_r.rx[14:0], r_r.mdi_s2};
                        end
                    end
                    else if (r_r.bit_cnt == pmc_pkg::FRM_LAST_BIT)
                    begin
                        // falling edge after the last bit: frame done
                        // command field back to idle as busy ends
                        r_nxt.state = pmc_pkg::ST_IDLE;
                        r_nxt.cmd = pmc_pkg::CMD_IDLE;
                        r_nxt.mdio_oe_n = 1'b1;
                        r_nxt.mdio_o = 1'b0;
                        // read result lands in the data register
                        if (is_read)
                        begin
                            r_nxt.data = r_r.rx;
                            r_nxt.rd_err = r_r.ta_fail;
                        end
                    end
                    else
                    begin
                        // falling edge: present the next bit
                        r_nxt.bit_cnt = r_r.bit_cnt + 7'h01;
                        r_nxt.shreg = {r_r.shreg[62:0], 1'b0};
                        r_nxt.mdio_o = r_r.shreg[62];
                        // reads release the line from the turnaround on
                        if (is_read && r_r.bit_cnt + 7'h01 >= pmc_pkg::FRM_RELEASE_BIT)
                        begin
                            r_nxt.mdio_oe_n = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r_r <= '{state: pmc_pkg::ST_IDLE, mdio_oe_n: 1'b1, default: '0}; // line released
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    assign m_rdata = r_r.m_rdata;
    assign l_rdata = r_r.l_rdata;
    assign mdc = r_r.mdc;
    assign mdio_out = r_r.mdio_o;
    assign mdio_oe_n = r_r.mdio_oe_n;

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_read_cmd;
        wr_ok && wa == pmc_pkg::OFS_CTRL_HI && wd[1:0] == pmc_pkg::CMD_READ && !busy;
    endsequence
    sequence s_engine_runs;
        busy && ctrl_hi[1:0] == pmc_pkg::CMD_READ;
    endsequence

    chk_we_local_one: assert property (r_r.l_claim && l_rd
        && l_addr == pmc_pkg::OFS_CTRL_LO |=> l_rdata[pmc_pkg::BIT_WE])
        else $error("write enable not shown while local host owns");
    chk_read_starts: assert property (s_read_cmd |=> s_engine_runs [*4])
        else $error("read command did not start the engine");
    chk_bad_code_err: assert property (wr_ok && wa == pmc_pkg::OFS_CTRL_HI
        && wd[1:0] == 2'h3 && !busy |=> r_r.cmd_err && !busy)
        else $error("reserved code did not raise command error");
    chk_idle_clears: assert property (wr_ok && wa == pmc_pkg::OFS_CTRL_HI
        && wd[1:0] == pmc_pkg::CMD_IDLE |=> !r_r.cmd_err && !r_r.rd_err)
        else $error("idle code left an error flag set");
    chk_busy_blocks: assert property (busy && (m_wr || l_wr)
        && $past(busy) |=> $stable(r_r.reg_sel) && $stable(r_r.phy_addr))
        else $error("register changed by a write while busy");
    chk_owner_only: assert property (r_r.l_claim && m_wr && !l_wr
        && m_addr == pmc_pkg::OFS_PHY_ADDR |=> $stable(r_r.phy_addr))
        else $error("non-owner write took effect");
    chk_sof_clears_we: assert property (sof && !(m_wr_ok
        && wa == pmc_pkg::OFS_CTRL_LO) |=> !r_r.we)
        else $error("write enable survived frame start");
    chk_cmd_idle_end: assert property ($fell(busy) |-> ctrl_hi[1:0]
        == pmc_pkg::CMD_IDLE && $past(ctrl_hi[1:0]) != pmc_pkg::CMD_IDLE)
        else $error("command field not idle when busy ended");
    chk_frame_length: assert property ($fell(busy) |-> r_r.busy_cnt
        == 12'(pmc_pkg::FRAME_CYCLES))
        else $error("frame length wrong");
    chk_busy_bit: assert property (ctrl_hi[pmc_pkg::BIT_BUSY] == busy
        && (!busy || ctrl_hi[1:0] != pmc_pkg::CMD_IDLE))
        else $error("busy bit or command readback wrong");
endmodule

//--- bench/pmc_phy_model.sv
/*
 behavioural management port of an external PHY.
 assumes the caller resolves the shared data line with a pull-up.
*/
`timescale 1ns/1ps
module pmc_phy_model (
    input wire logic mdc,
    input wire logic mdio_line,
    input wire logic respond,
    input wire logic [15:0] read_word,
    output logic drv_oe,
    output logic drv_val,
    output logic [63:0] last_frame
);
    int bit_i;
    logic [63:0] sh;
    logic rd_op;
    // ==========================================================
    // frame capture
    initial
    begin
        bit_i = 0;
        sh = '0;
        rd_op = 1'b0;
        drv_oe = 1'b0;
        drv_val = 1'b1;
        last_frame = '0;
    end
    // frame layout
    // sample on mdc rise; opcode known after bit 35
    always @(posedge mdc)
    begin
        sh = {sh[62:0], mdio_line};
        bit_i = bit_i + 1;
        if (bit_i == 36)
            rd_op = (sh[1:0] == 2'b10);
        if (bit_i == 64)
        begin
            last_frame <= sh;
            bit_i = 0;
        end
    end
    // answer after mdc fall; silent phy leaves the pull-up, so no ack
    always @(negedge mdc)
    begin
        drv_oe <= respond && rd_op && bit_i >= 47;
        drv_val <= (bit_i >= 48) ? read_word[4'(63 - bit_i)] : 1'b0;
    end
endmodule

//--- bench/pmc_controller_tb_top.sv
/*
 self-checking bench for the phy management controller.
 assumes byte-wide host strobes and a pulled-up management data line.
*/
`timescale 1ns/1ps
module pmc_controller_tb_top;
    logic ref_clk, arst_n, m_wr, m_rd, l_wr, l_rd, sof, l_access_end;
    logic [11:0] m_addr, l_addr;
    logic [7:0] m_wdata, l_wdata, m_rdata, l_rdata, v;
    logic mdc, mdio_in, mdio_out, mdio_oe_n, drv_oe, drv_val, respond;
    logic [15:0] rd_word;
    logic [63:0] last_frame;
    int n_fail, compares;
    // line level: device, then phy, else the pull-up
    assign mdio_in = !mdio_oe_n ? mdio_out : (drv_oe ? drv_val : 1'b1);
    pmc_controller #(.NUM_PORTS(4)) i_pmc_controller (.ref_clk(ref_clk), .arst_n(arst_n),
        .m_addr(m_addr), .m_wr(m_wr), .m_rd(m_rd), .m_wdata(m_wdata), .m_rdata(m_rdata),
        .l_addr(l_addr), .l_wr(l_wr), .l_rd(l_rd), .l_wdata(l_wdata), .l_rdata(l_rdata),
        .sof(sof), .l_access_end(l_access_end), .lh_ctrl_possible(1'b1),
        .link_detect_active(1'b1), .port0_phy_addr(5'h05),
        .port_phy_addrs({5'h13, 5'h12, 5'h11, 5'h10}), .port_link_status(32'hA5C31E7F),
        .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
    pmc_phy_model i_pmc_phy_model (.mdc(mdc), .mdio_line(mdio_in), .respond(respond),
        .read_word(rd_word), .drv_oe(drv_oe), .drv_val(drv_val), .last_frame(last_frame));
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // host 1 is the local host port, 0 the network master side
    task automatic wr(input logic h, input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        m_addr = a; l_addr = a; m_wdata = d; l_wdata = d; m_wr = !h; l_wr = h;
        @(posedge ref_clk);
        #1;
        m_wr = 1'b0; l_wr = 1'b0;
    endtask
    task automatic rd(input logic h, input logic [11:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        m_addr = a; l_addr = a; m_rd = !h; l_rd = h;
        @(posedge ref_clk);
        #1;
        m_rd = 1'b0; l_rd = 1'b0;
        d = h ? l_rdata : m_rdata;
    endtask
    task automatic rdc(input logic h, input logic [11:0] a, input logic [7:0] e);
        rd(h, a, v);
        chk(v, e);
    endtask
    task automatic pulse(input logic end_of_access);
        @(posedge ref_clk);
        #1;
        if (end_of_access) l_access_end = 1'b1; else sof = 1'b1;
        @(posedge ref_clk);
        #1;
        sof = 1'b0; l_access_end = 1'b0;
    endtask
    // bounded poll of the busy flag
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            rd(0, pmc_pkg::OFS_CTRL_HI, v);
            n++;
        end while (v[7] !== 1'b0 && n < 1000);
        chk(n < 1000, 1);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        rdc(0, pmc_pkg::OFS_CTRL_LO, 8'h2E);
        rdc(0, pmc_pkg::OFS_CTRL_HI, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_read();
        respond = 1'b1;
        rd_word = 16'hBEEF;
        wr(0, pmc_pkg::OFS_PHY_ADDR, 8'h0A);
        wr(0, pmc_pkg::OFS_REG_SEL, 8'h03);
        wr(0, pmc_pkg::OFS_CTRL_HI, 8'h01);
        rdc(0, pmc_pkg::OFS_CTRL_HI, 8'h81);
        wr(0, pmc_pkg::OFS_PHY_ADDR, 8'h1F);
        wait_idle();
        rdc(0, pmc_pkg::OFS_CTRL_HI, 8'h00);
        rdc(0, pmc_pkg::OFS_PHY_ADDR, 8'h0A);
        rdc(0, pmc_pkg::OFS_DATA_LO, 8'hEF);
        rdc(0, pmc_pkg::OFS_DATA_HI, 8'hBE);
        chk(last_frame[31:0], {4'h6, 5'h0A, 5'h03, 2'b10, 16'hBEEF});
        chk(last_frame[63:32], 32'hFFFFFFFF);
        wr(0, pmc_pkg::OFS_PHY_ADDR, 8'h82);
        rdc(0, pmc_pkg::OFS_CTRL_LO, 8'h96);
        wr(0, pmc_pkg::OFS_PHY_ADDR, 8'h0A);
        $display("test read done");
    endtask
    task automatic t_rderr();
        respond = 1'b0;
        wr(0, pmc_pkg::OFS_CTRL_HI, 8'h01);
        wait_idle();
        rdc(0, pmc_pkg::OFS_CTRL_HI, 8'h20);
        wr(0, pmc_pkg::OFS_CTRL_LO, 8'h00);
        rdc(0, pmc_pkg::OFS_CTRL_HI, 8'h00);
        $display("test read error done");
    endtask
    task automatic t_cmderr();
        wr(0, pmc_pkg::OFS_CTRL_HI, 8'h02);
        rdc(0, pmc_pkg::OFS_CTRL_HI, 8'h40);
        wr(0, pmc_pkg::OFS_CTRL_HI, 8'h00);
        rdc(0, pmc_pkg::OFS_CTRL_HI, 8'h00);
        // normal traffic never issues 11; sent once here to be refused
        wr(0, pmc_pkg::OFS_CTRL_HI, 8'h03);
        rdc(0, pmc_pkg::OFS_CTRL_HI, 8'h40);
        wr(0, pmc_pkg::OFS_CTRL_LO, 8'h01);
        wr(0, pmc_pkg::OFS_DATA_LO, 8'h34);
        wr(0, pmc_pkg::OFS_DATA_HI, 8'h12);
        wr(0, pmc_pkg::OFS_CTRL_HI, 8'h02);
        rdc(0, pmc_pkg::OFS_CTRL_HI, 8'h82);
        wait_idle();
        chk(last_frame[31:0], {4'h5, 5'h0A, 5'h03, 2'b10, 16'h1234});
        $display("test command error done");
    endtask
    task automatic t_we();
        wr(0, pmc_pkg::OFS_CTRL_LO, 8'h01);
        rdc(0, pmc_pkg::OFS_CTRL_LO, 8'h2F);
        pulse(1'b0);
        rdc(0, pmc_pkg::OFS_CTRL_LO, 8'h2E);
        wr(0, pmc_pkg::OFS_CTRL_LO, 8'h01);
        pulse(1'b1);
        rdc(0, pmc_pkg::OFS_CTRL_LO, 8'h2E);
        $display("test write enable done");
    endtask
    task automatic t_own();
        wr(1, pmc_pkg::OFS_PHY_ADDR, 8'h11);
        rdc(1, pmc_pkg::OFS_PHY_ADDR, 8'h0A);
        wr(1, pmc_pkg::OFS_L_CLAIM, 8'h01);
        rd(1, pmc_pkg::OFS_L_CLAIM, v);
        chk(v[0], 1'b1);
        rdc(1, pmc_pkg::OFS_CTRL_LO, 8'h2F);
        wr(0, pmc_pkg::OFS_PHY_ADDR, 8'h11);
        rdc(0, pmc_pkg::OFS_PHY_ADDR, 8'h0A);
        wr(1, pmc_pkg::OFS_PHY_ADDR, 8'h07);
        rdc(1, pmc_pkg::OFS_PHY_ADDR, 8'h07);
        wr(0, pmc_pkg::OFS_L_CLAIM, 8'h02);
        rd(0, pmc_pkg::OFS_L_CLAIM, v);
        chk(v[0], 1'b0);
        $display("test ownership done");
    endtask
    // ==========================================================
    // verdict, clock, watchdog and main sequence
    task automatic report_and_stop();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = !ref_clk;
    end
    // about four thousand cycles expected; give five times that
    initial
    begin
        #1000000;
        n_fail++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        report_and_stop();
    end
    initial
    begin
        n_fail = 0; compares = 0; arst_n = 1'b0; respond = 1'b1; rd_word = 16'h0000;
        m_wr = 1'b0; m_rd = 1'b0; l_wr = 1'b0; l_rd = 1'b0; sof = 1'b0; l_access_end = 1'b0;
        m_addr = '0; l_addr = '0; m_wdata = '0; l_wdata = '0;
        repeat (3) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_read();
        t_rderr();
        t_cmderr();
        t_we();
        t_own();
        report_and_stop();
    end
endmodule
